/* core/mbsf_framer.sv */
// Summary of operation
// RULE1 - frames over eighty bytes are invalid; replies never exceed eighty bytes
// RULE2 - ascii frames open with colon and close with CR then LF
// RULE3 - ascii fields are hex pairs: address, function, lrc two, address/length four
// RULE4 - only the master starts; the device only answers requests addressed to it
// RULE5 - rtu frame is address, function, data, then two crc bytes
// RULE6 - the master waits ten milliseconds between exchanges
// RULE7 - station address zero is a broadcast every drive accepts
// RULE8 - nonzero addresses select the drive whose number, 01 to 20 hex, matches
// RULE9 - functions 03 read, 06 write one word, 10 write several words
// RULE10 - function 08 is a loop-back test echoing the request
// RULE11 - rtu crc covers address through last data byte, not itself
// RULE12 - crc starts from all ones
// RULE13 - each byte is xored into the crc low byte first
// RULE14 - each step shifts right with zero fill, examining the bit out
// RULE15 - a one shifted out xors the polynomial a001
// RULE16 - eight steps per byte; final value is the crc
// RULE17 - crc is sent low byte first, then high byte
// RULE18 - errors reply with function code plus 80 hex
// RULE19 - exception codes 51 function, 52 address, 53 amount, 54 range, 55 write mode
// RULE20 - ascii lrc is the negated eight-bit sum of decoded bytes
// RULE21 - bad check or foreign address frames are dropped silently
`timescale 1ns/1ps
module mbsf_framer
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic ascii_mode_in,
   input wire logic [7:0] station_in,
   input wire logic [7:0] rx_data_in,
   input wire logic rx_valid_in,
   output logic rx_ready_out,
   input wire logic rx_end_in,
   output logic [7:0] tx_data_out,
   output logic tx_valid_out,
   input wire logic tx_ready_in,
   output logic [15:0] reg_addr_out,
   output logic [15:0] reg_wdata_out,
   output logic reg_rd_out,
   output logic reg_wr_out,
   input wire logic [15:0] reg_rdata_in,
   input wire logic [1:0] reg_err_in
);

   logic [7:0] buf_r [0:79];
   mbsf_pkg::mbsf_state_type state_r, state_nxt;
   logic ascii_r, ascii_nxt, inf_r, inf_nxt, cr_r, cr_nxt, nib_r, nib_nxt;
   logic bad_r, bad_nxt, ovf_r, ovf_nxt, bc_r, bc_nxt, ph_r, ph_nxt;
   logic rd_r, rd_nxt, wr_r, wr_nxt;
   logic [3:0] hi_r, hi_nxt;
   logic [1:0] tp_r, tp_nxt;
   logic [6:0] cnt_r, cnt_nxt, rc_r, rc_nxt, idx_r, idx_nxt, tlen_r, tlen_nxt;
   logic [7:0] sum_r, sum_nxt, fn_r, fn_nxt, code_r, code_nxt;
   logic [15:0] start_r, start_nxt, num_r, num_nxt, addr_r, addr_nxt, wd_r, wd_nxt;
   logic wa_en, wb_en;
   logic [6:0] wa_idx, wb_idx, plen, didx;
   logic [7:0] wa_val, wb_val, lrc, cur;
   logic [4:0] hv;
   logic take, crc_init, crc_feed, crc_busy, addr_ok, chk_ok;
   logic [7:0] crc_byte, q_data;
   logic q_valid, q_ready;
   logic [15:0] crc_val;

   function automatic logic [4:0] hex_dec(input logic [7:0] c);
      logic [4:0] r;
      r = 5'h00;
      if (c >= 8'h30 && c <= 8'h39)
         r = {1'b1, 4'(c - 8'h30)};
      else if (c >= 8'h41 && c <= 8'h46)
         r = {1'b1, 4'(c - 8'h37)};
      else if (c >= 8'h61 && c <= 8'h66)
         r = {1'b1, 4'(c - 8'h57)};
      return r;
   endfunction : hex_dec

   function automatic logic [7:0] hex_enc(input logic [3:0] n);
      logic [7:0] r;
      r = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
      return r;
   endfunction : hex_enc

   ////////////////////////////////////////////////////////////////////////////
   mbsf_crc16 u_crc
   (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .init_in(crc_init),
      .feed_in(crc_feed),
      .byte_in(crc_byte),
      .busy_out(crc_busy),
      .crc_out(crc_val)
   );

   mbsf_skid u_txq
   (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .in_data_in(q_data),
      .in_valid_in(q_valid),
      .in_ready_out(q_ready),
      .out_data_out(tx_data_out),
      .out_valid_out(tx_valid_out),
      .out_ready_in(tx_ready_in)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      state_nxt = state_r;
      ascii_nxt = ascii_r;
      inf_nxt = inf_r;
      cr_nxt = cr_r;
      nib_nxt = nib_r;
      bad_nxt = bad_r;
      ovf_nxt = ovf_r;
      bc_nxt = bc_r;
      ph_nxt = ph_r;
      rd_nxt = 1'b0;
      wr_nxt = 1'b0;
      hi_nxt = hi_r;
      tp_nxt = tp_r;
      cnt_nxt = cnt_r;
      rc_nxt = rc_r;
      idx_nxt = idx_r;
      tlen_nxt = tlen_r;
      sum_nxt = sum_r;
      fn_nxt = fn_r;
      code_nxt = code_r;
      start_nxt = start_r;
      num_nxt = num_r;
      addr_nxt = addr_r;
      wd_nxt = wd_r;
      wa_en = 1'b0;
      wa_idx = cnt_r;
      wa_val = 8'h00;
      wb_en = 1'b0;
      wb_idx = 7'h00;
      wb_val = 8'h00;
      crc_init = 1'b0;
      crc_feed = 1'b0;
      crc_byte = rx_data_in;
      q_valid = 1'b0;
      q_data = 8'h00;
      rx_ready_out = (state_r == mbsf_pkg::ST_IDLE) && !crc_busy && !ph_r;
      take = rx_valid_in && rx_ready_out;
      hv = hex_dec(rx_data_in);
      plen = cnt_r - (ascii_r ? 7'h01 : 7'h02);
      lrc = 8'h00 - sum_r; // RULE20
      cur = buf_r[idx_r];
      didx = (fn_r == mbsf_pkg::FN_WRITEN) ? (7'h07 + {idx_r[5:0], 1'b0}) : 7'h04;
      addr_ok = (buf_r[0] == mbsf_pkg::ADDR_BCAST) || // RULE7
         (buf_r[0] == station_in && station_in >= mbsf_pkg::ADDR_MIN &&
         station_in <= mbsf_pkg::ADDR_MAX); // RULE8
      chk_ok = !ovf_r && !bad_r && !nib_r && (ascii_r ? (cnt_r >= 7'h03 && sum_r == 8'h00)
         : (cnt_r >= 7'h04 && crc_val == 16'h0000)); // RULE11
      case (state_r)
         mbsf_pkg::ST_IDLE:
         begin
            if (ascii_mode_in && take && rx_data_in == mbsf_pkg::CH_COLON)
            begin
               // a colon restarts reception even inside a broken frame
               ascii_nxt = 1'b1; // RULE2
               inf_nxt = 1'b1;
               {cr_nxt, nib_nxt, bad_nxt, ovf_nxt} = 4'h0;
               cnt_nxt = 7'h00;
               rc_nxt = 7'h01;
               sum_nxt = 8'h00;
            end
            else if (ascii_mode_in && take && inf_r)
            begin
               rc_nxt = rc_r + 7'h01;
               if (rc_r == mbsf_pkg::MAX_FRAME)
                  ovf_nxt = 1'b1; // RULE1
               if (rx_data_in == mbsf_pkg::CH_CR)
                  cr_nxt = 1'b1;
               else if (rx_data_in == mbsf_pkg::CH_LF && cr_r)
               begin
                  inf_nxt = 1'b0;
                  state_nxt = mbsf_pkg::ST_CHECK; // RULE2
               end
               else if (!hv[4] || cr_r)
                  bad_nxt = 1'b1;
               else if (!nib_r)
               begin
                  hi_nxt = hv[3:0]; // RULE3
                  nib_nxt = 1'b1;
               end
               else
               begin
                  nib_nxt = 1'b0;
                  if (cnt_r < mbsf_pkg::MAX_FRAME)
                  begin
                     wa_en = 1'b1;
                     wa_val = {hi_r, hv[3:0]};
                     cnt_nxt = cnt_r + 7'h01;
                  end
                  sum_nxt = sum_r + {hi_r, hv[3:0]};
               end
            end
            else if (!ascii_mode_in && take)
            begin
               ascii_nxt = 1'b0;
               inf_nxt = 1'b1;
               crc_feed = 1'b1;
               crc_init = !inf_r;
               if (!inf_r)
               begin
                  // first byte: preset and feed would collide, so stash and feed later
                  crc_feed = 1'b0;
                  ovf_nxt = 1'b0;
                  bad_nxt = 1'b0;
                  nib_nxt = 1'b0;
                  cnt_nxt = 7'h01;
                  rc_nxt = 7'h01;
                  wa_idx = 7'h00;
                  ph_nxt = 1'b1;
               end
               else
               begin
                  rc_nxt = rc_r + 7'h01;
                  if (rc_r == mbsf_pkg::MAX_FRAME)
                     ovf_nxt = 1'b1; // RULE1
                  if (cnt_r < mbsf_pkg::MAX_FRAME)
                     cnt_nxt = cnt_r + 7'h01;
               end
               wa_en = (cnt_r < mbsf_pkg::MAX_FRAME) || !inf_r;
               wa_val = rx_data_in; // RULE5
            end
            else if (!ascii_mode_in && inf_r && ph_r && !crc_busy)
            begin
               crc_feed = 1'b1;
               crc_byte = buf_r[0];
               ph_nxt = 1'b0;
            end
            else if (!ascii_mode_in && inf_r && rx_end_in && !ph_r)
            begin
               inf_nxt = 1'b0;
               state_nxt = mbsf_pkg::ST_RXWAIT;
            end
         end
         mbsf_pkg::ST_RXWAIT:
            if (!crc_busy)
               state_nxt = mbsf_pkg::ST_CHECK;
         mbsf_pkg::ST_CHECK:
         begin
            fn_nxt = buf_r[1];
            bc_nxt = (buf_r[0] == mbsf_pkg::ADDR_BCAST);
            start_nxt = {buf_r[2], buf_r[3]};
            num_nxt = (buf_r[1] == mbsf_pkg::FN_WRITE1) ? 16'h0001 : {buf_r[4], buf_r[5]};
            idx_nxt = 7'h00;
            ph_nxt = 1'b0;
            code_nxt = 8'h00;
            state_nxt = mbsf_pkg::ST_EXEC;
            if (!chk_ok || !addr_ok)
               state_nxt = mbsf_pkg::ST_IDLE; // RULE21
            else if (buf_r[1] == mbsf_pkg::FN_LOOP)
            begin
               tlen_nxt = plen; // RULE10
               state_nxt = mbsf_pkg::ST_RESP;
            end
            else if (buf_r[1] != mbsf_pkg::FN_READ && buf_r[1] != mbsf_pkg::FN_WRITE1 &&
               buf_r[1] != mbsf_pkg::FN_WRITEN)
               code_nxt = mbsf_pkg::EX_FUNC; // RULE19
            else if (buf_r[1] == mbsf_pkg::FN_WRITE1 ? plen != 7'h06 :
               ({buf_r[4], buf_r[5]} == 16'h0000 || {buf_r[4], buf_r[5]} > mbsf_pkg::MAX_WORDS ||
               (buf_r[1] == mbsf_pkg::FN_READ ? plen != 7'h06 :
               (buf_r[6] != {buf_r[5][6:0], 1'b0} || plen != 7'h07 + buf_r[6][6:0]))))
               code_nxt = mbsf_pkg::EX_AMOUNT; // RULE19
            if (chk_ok && addr_ok && buf_r[1] != mbsf_pkg::FN_LOOP &&
               buf_r[1] != mbsf_pkg::FN_READ && buf_r[1] != mbsf_pkg::FN_WRITE1 &&
               buf_r[1] != mbsf_pkg::FN_WRITEN)
               state_nxt = mbsf_pkg::ST_RESP;
         end
         mbsf_pkg::ST_EXEC:
         begin
            if (code_r != 8'h00 || idx_r == num_r[6:0])
            begin
               state_nxt = mbsf_pkg::ST_RESP;
               tlen_nxt = 7'h06;
               if (fn_r == mbsf_pkg::FN_READ)
               begin
                  wb_en = 1'b1;
                  wb_idx = 7'h02;
                  wb_val = {idx_r, 1'b0};
                  tlen_nxt = 7'h03 + {idx_r[5:0], 1'b0};
               end
            end
            else if (!ph_r)
            begin
               addr_nxt = start_r + {9'h000, idx_r};
               wd_nxt = {buf_r[didx], buf_r[didx + 7'h01]};
               rd_nxt = (fn_r == mbsf_pkg::FN_READ); // RULE9
               wr_nxt = (fn_r != mbsf_pkg::FN_READ); // RULE9
               ph_nxt = 1'b1;
            end
            else
            begin
               ph_nxt = 1'b0;
               idx_nxt = idx_r + 7'h01;
               if (reg_err_in != mbsf_pkg::RSP_OK)
                  code_nxt = (reg_err_in == mbsf_pkg::RSP_ADDR) ? mbsf_pkg::EX_ADDR :
                     (reg_err_in == mbsf_pkg::RSP_RANGE) ? mbsf_pkg::EX_RANGE :
                     mbsf_pkg::EX_WMODE; // RULE19
               else if (rd_r)
               begin
                  wa_en = 1'b1;
                  wa_idx = 7'h03 + {idx_r[5:0], 1'b0};
                  wa_val = reg_rdata_in[15:8];
                  wb_en = 1'b1;
                  wb_idx = 7'h04 + {idx_r[5:0], 1'b0};
                  wb_val = reg_rdata_in[7:0];
               end
            end
         end
         mbsf_pkg::ST_RESP:
         begin
            idx_nxt = 7'h00;
            state_nxt = bc_r ? mbsf_pkg::ST_IDLE : mbsf_pkg::ST_TXHEAD; // RULE4
            if (code_r != 8'h00)
            begin
               wa_en = 1'b1;
               wa_idx = 7'h01;
               wa_val = fn_r | mbsf_pkg::FN_EXC_FLAG; // RULE18
               wb_en = 1'b1;
               wb_idx = 7'h02;
               wb_val = code_r;
               tlen_nxt = 7'h03;
            end
         end
         mbsf_pkg::ST_TXHEAD:
         begin
            sum_nxt = 8'h00;
            nib_nxt = 1'b0;
            tp_nxt = 2'h0;
            crc_init = !ascii_r;
            q_valid = ascii_r;
            q_data = mbsf_pkg::CH_COLON; // RULE2
            if (q_ready || !ascii_r)
               state_nxt = mbsf_pkg::ST_TXBODY;
         end
         mbsf_pkg::ST_TXBODY:
         begin
            if (idx_r == tlen_r)
            begin
               if (!crc_busy)
                  state_nxt = mbsf_pkg::ST_TXTAIL;
            end
            else if (ascii_r)
            begin
               q_valid = 1'b1;
               q_data = hex_enc(nib_r ? cur[3:0] : cur[7:4]); // RULE3
               if (q_ready)
               begin
                  nib_nxt = !nib_r;
                  if (nib_r)
                  begin
                     sum_nxt = sum_r + cur;
                     idx_nxt = idx_r + 7'h01;
                  end
               end
            end
            else if (!crc_busy)
            begin
               q_valid = 1'b1;
               q_data = cur;
               crc_byte = cur;
               crc_feed = q_ready; // RULE11
               if (q_ready)
                  idx_nxt = idx_r + 7'h01;
            end
         end
         mbsf_pkg::ST_TXTAIL:
         begin
            q_valid = 1'b1;
            case (tp_r)
               2'h0: q_data = ascii_r ? hex_enc(lrc[7:4]) : crc_val[7:0]; // RULE17
               2'h1: q_data = ascii_r ? hex_enc(lrc[3:0]) : crc_val[15:8]; // RULE17
               2'h2: q_data = mbsf_pkg::CH_CR;
               default: q_data = mbsf_pkg::CH_LF;
            endcase
            if (q_ready)
            begin
               tp_nxt = tp_r + 2'h1;
               if (tp_r == 2'h3 || (!ascii_r && tp_r == 2'h1))
                  state_nxt = mbsf_pkg::ST_IDLE;
            end
         end
         default:
            state_nxt = mbsf_pkg::ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         state_r <= mbsf_pkg::ST_IDLE;
         {ascii_r, inf_r, cr_r, nib_r, bad_r, ovf_r, bc_r, ph_r, rd_r, wr_r} <= 10'h000;
         hi_r <= 4'h0;
         tp_r <= 2'h0;
         {cnt_r, rc_r, idx_r, tlen_r} <= 28'h000_0000;
         {sum_r, fn_r, code_r} <= 24'h00_0000;
         {start_r, num_r, addr_r, wd_r} <= 64'h0000_0000_0000_0000;
      end
      else
      begin
         state_r <= state_nxt;
         {ascii_r, inf_r, cr_r, nib_r, bad_r} <= {ascii_nxt, inf_nxt, cr_nxt, nib_nxt, bad_nxt};
         {ovf_r, bc_r, ph_r, rd_r, wr_r} <= {ovf_nxt, bc_nxt, ph_nxt, rd_nxt, wr_nxt};
         hi_r <= hi_nxt;
         tp_r <= tp_nxt;
         {cnt_r, rc_r, idx_r, tlen_r} <= {cnt_nxt, rc_nxt, idx_nxt, tlen_nxt};
         {sum_r, fn_r, code_r} <= {sum_nxt, fn_nxt, code_nxt};
         {start_r, num_r, addr_r, wd_r} <= {start_nxt, num_nxt, addr_nxt, wd_nxt};
      end
   end

   // frame store holds no control state, so it needs no reset
   always_ff @(posedge clk_in)
   begin
      if (wa_en)
         buf_r[wa_idx] <= wa_val;
      if (wb_en)
         buf_r[wb_idx] <= wb_val;
   end

   assign reg_addr_out = addr_r;
   assign reg_wdata_out = wd_r;
   assign reg_rd_out = rd_r;
   assign reg_wr_out = wr_r;

endmodule : mbsf_framer

/* inc/mbsf_pkg.sv */
package mbsf_pkg;

   // frame limits and framing characters
   localparam logic [6:0] MAX_FRAME = 7'h50;
   localparam logic [7:0] CH_COLON = 8'h3a;
   localparam logic [7:0] CH_CR = 8'h0d;
   localparam logic [7:0] CH_LF = 8'h0a;

   // crc-16 arithmetic
   localparam logic [15:0] CRC_PRESET = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   localparam logic [3:0] CRC_STEPS = 4'h8;

   // station numbering
   localparam logic [7:0] ADDR_BCAST = 8'h00;
   localparam logic [7:0] ADDR_MIN = 8'h01;
   localparam logic [7:0] ADDR_MAX = 8'h20;

   // function codes
   localparam logic [7:0] FN_READ = 8'h03;
   localparam logic [7:0] FN_WRITE1 = 8'h06;
   localparam logic [7:0] FN_LOOP = 8'h08;
   localparam logic [7:0] FN_WRITEN = 8'h10;
   localparam logic [7:0] FN_EXC_FLAG = 8'h80;

   // exception codes
   localparam logic [7:0] EX_FUNC = 8'h51;
   localparam logic [7:0] EX_ADDR = 8'h52;
   localparam logic [7:0] EX_AMOUNT = 8'h53;
   localparam logic [7:0] EX_RANGE = 8'h54;
   localparam logic [7:0] EX_WMODE = 8'h55;

   // register port answer codes
   localparam logic [1:0] RSP_OK = 2'h0;
   localparam logic [1:0] RSP_ADDR = 2'h1;
   localparam logic [1:0] RSP_RANGE = 2'h2;

   // word count per request, kept so every reply fits the frame limit in both modes
   localparam logic [15:0] MAX_WORDS = 16'h0010;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RXWAIT,
      ST_CHECK,
      ST_EXEC,
      ST_RESP,
      ST_TXHEAD,
      ST_TXBODY,
      ST_TXTAIL
   } mbsf_state_type;

endpackage : mbsf_pkg

/* core/mbsf_crc16.sv */
`timescale 1ns/1ps
module mbsf_crc16
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic init_in,
   input wire logic feed_in,
   input wire logic [7:0] byte_in,
   output logic busy_out,
   output logic [15:0] crc_out
);

   logic [15:0] crc_r;
   logic [15:0] crc_nxt;
   logic [3:0] step_r;
   logic [3:0] step_nxt;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      crc_nxt = crc_r;
      step_nxt = step_r;
      if (init_in)
      begin
         crc_nxt = mbsf_pkg::CRC_PRESET; // RULE12
         step_nxt = 4'h0;
      end
      else if (feed_in && step_r == 4'h0)
      begin
         crc_nxt = {crc_r[15:8], crc_r[7:0] ^ byte_in}; // RULE13
         step_nxt = mbsf_pkg::CRC_STEPS; // RULE16
      end
      else if (step_r != 4'h0)
      begin
         // one bit per cycle keeps the datapath to a single shifter
         if (crc_r[0])
            crc_nxt = {1'b0, crc_r[15:1]} ^ mbsf_pkg::CRC_POLY; // RULE15
         else
            crc_nxt = {1'b0, crc_r[15:1]}; // RULE14
         step_nxt = step_r - 4'h1;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         crc_r <= mbsf_pkg::CRC_PRESET;
         step_r <= 4'h0;
      end
      else
      begin
         crc_r <= crc_nxt;
         step_r <= step_nxt;
      end
   end

   assign busy_out = (step_r != 4'h0);
   assign crc_out = crc_r;

endmodule : mbsf_crc16

/* core/mbsf_skid.sv */
`timescale 1ns/1ps
module mbsf_skid
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [7:0] in_data_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   output logic [7:0] out_data_out,
   output logic out_valid_out,
   input wire logic out_ready_in
);

   logic [7:0] mem_r [0:1];
   logic wp_r;
   logic wp_nxt;
   logic rp_r;
   logic rp_nxt;
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;
   logic push;
   logic pop;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      push = in_valid_in && (cnt_r != 2'h2);
      pop = out_ready_in && (cnt_r != 2'h0);
      wp_nxt = push ? ~wp_r : wp_r;
      rp_nxt = pop ? ~rp_r : rp_r;
      cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
         mem_r[0] <= 8'h00;
         mem_r[1] <= 8'h00;
      end
      else
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
         if (push)
            mem_r[wp_r] <= in_data_in;
      end
   end

   assign in_ready_out = (cnt_r != 2'h2);
   assign out_valid_out = (cnt_r != 2'h0);
   assign out_data_out = mem_r[rp_r];

endmodule : mbsf_skid

/* dv/mbsf_reg_model.sv */
`timescale 1ns/1ps
module mbsf_reg_model
(
   input wire logic clk_in,
   input wire logic [15:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out,
   output logic [1:0] err_out
);
   logic [15:0] mem_r [0:255];
   ////////////////////////////////////////////////////////////////////////////////
   // pages 3, 4 and 5 refuse with address, range and write-mode errors
   always_comb
   begin
      err_out = (addr_in[15:12] inside {[4'h3:4'h5]}) ? addr_in[13:12] + 2'h2 : 2'h0;
      // outside a strobe the word is inverted so a late sample cannot pass
      rdata_out = rd_in ? mem_r[addr_in[7:0]] : ~mem_r[addr_in[7:0]];
   end
   always_ff @(posedge clk_in)
      if (wr_in && err_out == 2'h0)
         mem_r[addr_in[7:0]] <= wdata_in;
endmodule : mbsf_reg_model

/* dv/mbsf_framer_checker.sv */
`timescale 1ns/1ps
module mbsf_framer_checker
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic ascii_mode_in,
   input wire logic rx_valid_in,
   input wire logic rx_ready_out,
   input wire logic [7:0] tx_data_out,
   input wire logic tx_valid_out,
   input wire logic tx_ready_in,
   input wire logic [15:0] reg_addr_out,
   input wire logic reg_rd_out,
   input wire logic reg_wr_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);
   sequence s_rd_pair;
      reg_rd_out ##2 reg_rd_out;
   endsequence
   sequence s_rtu_take;
      rx_valid_in && rx_ready_out && !ascii_mode_in;
   endsequence
   chk_rd_single: assert property (reg_rd_out |=> !reg_rd_out)
      else $error("read strobe longer than one cycle");
   chk_wr_single: assert property (reg_wr_out |=> !reg_wr_out)
      else $error("write strobe longer than one cycle");
   chk_strobe_excl: assert property (!(reg_rd_out && reg_wr_out))
      else $error("read and write strobes together");
   chk_addr_ascend: assert property (s_rd_pair |->
      reg_addr_out == $past(reg_addr_out, 2) + 16'h0001)
      else $error("read words not in ascending order");
   chk_addr_hold: assert property ((reg_rd_out || reg_wr_out) |=> $stable(reg_addr_out))
      else $error("register number moved after strobe");
   chk_crc_gap: assert property (s_rtu_take |=> !rx_ready_out [*8])
      else $error("byte accepted before eight crc steps");
   chk_tx_hold: assert property (tx_valid_out && !tx_ready_in |=>
      tx_valid_out && $stable(tx_data_out))
      else $error("reply byte changed before taken");
   chk_exec_busy: assert property ((reg_rd_out || reg_wr_out) |-> !rx_ready_out)
      else $error("receiving while executing");
endmodule : mbsf_framer_checker
bind mbsf_framer mbsf_framer_checker i_chk (.clk_in, .nrst_in, .ascii_mode_in, .rx_valid_in,
   .rx_ready_out, .tx_data_out, .tx_valid_out, .tx_ready_in, .reg_addr_out, .reg_rd_out, .reg_wr_out);

/* dv/mbsf_framer_tb.sv */
`timescale 1ns/1ps
module mbsf_framer_tb;
   localparam logic [7:0] STN = 8'h07;
   logic clk_in = 1'b0, nrst_in = 1'b0, ascii_mode_in = 1'b0;
   logic rx_valid_in = 1'b0, rx_end_in = 1'b0, tx_ready_in = 1'b0;
   logic rx_ready_out, tx_valid_out, reg_rd_out, reg_wr_out;
   logic [7:0] rx_data_in = 8'h00, tx_data_out, exp_q[$], fr[$];
   logic [15:0] reg_addr_out, reg_wdata_out, reg_rdata_in, w0, w1, lf = 16'h5eb9;
   logic [1:0] reg_err_in;
   logic [7:0] xf [5] = '{8'h05, 8'h03, 8'h03, 8'h06, 8'h06};
   logic [7:0] xa [5] = '{8'h00, 8'h00, 8'h30, 8'h40, 8'h50};
   logic [7:0] xl [5] = '{8'h01, 8'h11, 8'h01, 8'h01, 8'h01};
   logic [7:0] xc [5] = '{8'h51, 8'h53, 8'h52, 8'h54, 8'h55};
   int error_cnt = 0, compares = 0, cyc = 0;
   always #2.5 clk_in = ~clk_in;
   mbsf_framer i_dut (.clk_in, .nrst_in, .ascii_mode_in, .station_in(STN), .rx_data_in,
      .rx_valid_in, .rx_ready_out, .rx_end_in, .tx_data_out, .tx_valid_out, .tx_ready_in,
      .reg_addr_out, .reg_wdata_out, .reg_rd_out, .reg_wr_out, .reg_rdata_in, .reg_err_in);
   mbsf_reg_model i_regs (.clk_in, .addr_in(reg_addr_out), .wdata_in(reg_wdata_out),
      .wr_in(reg_wr_out), .rd_in(reg_rd_out), .rdata_out(reg_rdata_in), .err_out(reg_err_in));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c = 16'hffff;
      foreach (q[i])
      begin
         c ^= {8'h00, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      return c;
   endfunction : crc16
   function automatic logic [7:0] lrc(input logic [7:0] q[$]);
      logic [7:0] s = 8'h00;
      foreach (q[i]) s += q[i];
      return -s;
   endfunction : lrc
   function automatic logic [7:0] hc(input logic [3:0] n);
      return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
   endfunction : hc
   task automatic final_report;
      if (error_cnt == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report
   // the receiving master stalls about one cycle in four
   always @(negedge clk_in)
   begin
      lf <= {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      tx_ready_in <= lf[0] | lf[1];
   end
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         error_cnt++;
         $display("BAD %0t timeout", $time);
         final_report;
      end
      if (nrst_in && tx_valid_out && tx_ready_in)
      begin
         compares++;
         if (exp_q.size() == 0 || exp_q[0] !== tx_data_out)
         begin
            error_cnt++;
            $display("BAD %0t reply byte %h", $time, tx_data_out);
         end
         if (exp_q.size() != 0)
            void'(exp_q.pop_front());
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic put(input logic [7:0] b);
      rx_valid_in = 1'b1;
      rx_data_in = b;
      while (rx_ready_out !== 1'b1) @(negedge clk_in);
      @(negedge clk_in);
   endtask : put
   task automatic expect_reply(input logic asc, input logic [7:0] r[$]);
      logic [15:0] c;
      c = crc16(r);
      if (asc)
         r.push_back(lrc(r));
      else
         r = {r, c[7:0], c[15:8]};
      if (asc)
         exp_q.push_back(8'h3a);
      foreach (r[i])
         if (asc)
            exp_q = {exp_q, hc(r[i][7:4]), hc(r[i][3:0])};
         else
            exp_q.push_back(r[i]);
      if (asc)
         exp_q = {exp_q, 8'h0d, 8'h0a};
   endtask : expect_reply
   task automatic send(input logic asc, input logic bad);
      logic [15:0] c;
      ascii_mode_in = asc;
      c = asc ? {8'h00, lrc(fr)} ^ {15'h0000, bad} : crc16(fr) ^ {15'h0000, bad};
      if (asc)
         put(8'h3a);
      foreach (fr[i])
         if (asc)
         begin
            put(hc(fr[i][7:4]));
            put(hc(fr[i][3:0]));
         end
         else
            put(fr[i]);
      put(asc ? hc(c[7:4]) : c[7:0]);
      put(asc ? hc(c[3:0]) : c[15:8]);
      if (asc)
      begin
         put(8'h0d);
         put(8'h0a);
      end
      rx_valid_in = 1'b0;
      while (rx_ready_out !== 1'b1) @(negedge clk_in);
      rx_end_in = !asc;
      @(negedge clk_in);
      rx_end_in = 1'b0;
      for (int n = 0; n < 3000 && exp_q.size() != 0; n++) @(negedge clk_in);
      repeat (300) @(negedge clk_in);
   endtask : send
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3) @(negedge clk_in);
      nrst_in = 1'b1;
      w0 = lf;
      w1 = ~lf;
      fr = {8'h00, 8'h10, 8'h00, 8'h20, 8'h00, 8'h02, 8'h04, w0[15:8], w0[7:0], w1[15:8], w1[7:0]};
      send(1'b0, 1'b0);
      fr = {8'h00, 8'h06, 8'h00, 8'h22, w1[7:0], w0[7:0]};
      send(1'b0, 1'b0);
      fr = {STN, 8'h03, 8'h00, 8'h20, 8'h00, 8'h03};
      expect_reply(1'b0, {STN, 8'h03, 8'h06, w0[15:8], w0[7:0], w1[15:8], w1[7:0],
         w1[7:0], w0[7:0]});
      send(1'b0, 1'b0);
      fr = {STN, 8'h03, 8'h00, 8'h21, 8'h00, 8'h01};
      expect_reply(1'b1, {STN, 8'h03, 8'h02, w1[15:8], w1[7:0]});
      send(1'b1, 1'b0);
      fr = {STN, 8'h08, 8'h00, 8'h00, lf[15:8], lf[7:0]};
      expect_reply(1'b0, fr);
      send(1'b0, 1'b0);
      for (int i = 0; i < 5; i++)
      begin
         fr = {STN, xf[i], xa[i], 8'h00, 8'h00, xl[i]};
         expect_reply(i == 0, {STN, xf[i] | 8'h80, xc[i]});
         send(i == 0, 1'b0);
      end
      send(1'b0, 1'b1);
      send(1'b1, 1'b1);
      fr[0] = STN + 8'h01;
      send(1'b0, 1'b0);
      fr = {STN, 8'h08};
      repeat (79) fr.push_back(lf[7:0]);
      send(1'b0, 1'b0);
      if (exp_q.size() != 0)
      begin
         error_cnt++;
         $display("BAD %0t reply missing", $time);
      end
      final_report;
   end
endmodule : mbsf_framer_tb
